// ==== rsd_pkg.sv ====
// Purpose: shared constants and frame check for the serial command link
// Assumes: 100 MHz clock, 19200 bit/s line, 11 bits per character
// Notes: link carries whole bytes as one-cycle strobes, spaced one char time
package rsd_pkg;
    // =========================================================
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BIT_RATE = 19200;
    localparam int CHAR_BITS = 11;
    localparam int GAP_HALF_CHARS = 7;
    localparam int CHAR_CYC_DEF = (CLK_HZ / BIT_RATE) * CHAR_BITS;
    // least time, so rounded up
    localparam int GAP_CYC_DEF = (CHAR_CYC_DEF * GAP_HALF_CHARS + 1) / 2;
    localparam int RSP_TMO_CYC_DEF = CHAR_CYC_DEF * 20;
    // =========================================================
    // frame layout
    localparam logic [7:0] CMD_DIAG = 8'h08;
    localparam logic [7:0] CMD_WRMULT = 8'h10;
    localparam logic [15:0] SUB_ECHO = 16'h0000;
    localparam logic [15:0] MAX_WORDS = 16'h0010;
    localparam int BUF_LEN = 41;
    localparam logic [5:0] DIAG_LEN = 6'h08;
    localparam logic [5:0] RSP_LEN = 6'h06;
    localparam logic [5:0] WR_HDR = 6'h07;
    localparam logic [7:0] WR_OVH = 8'h09;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    // =========================================================
    // parameter addressing
    localparam int VOL_BIT = 15;
    localparam logic [6:0] FACTORY_GRP = 7'h63;
    localparam logic [15:0] ADDR_RUN_MODE = 16'h0A00;
    localparam logic [15:0] ADDR_PWR_MEM = 16'h0A01;
    localparam logic [15:0] RUN_MODE_MAX = 16'h0002;
    localparam logic [15:0] PWR_MEM_MAX = 16'h0001;
    localparam logic [15:0] RUN_MODE_RST = 16'h0000;
    localparam logic [15:0] PWR_MEM_RST = 16'h0000;
    // =========================================================
    // controller registers (byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STN = 12'h004;
    localparam logic [11:0] REG_ADDR = 12'h008;
    localparam logic [11:0] REG_QTY = 12'h00C;
    localparam logic [11:0] REG_STAT = 12'h010;
    localparam logic [5:0] REG_DATA_PAGE = 6'h01;
    localparam int CTRL_GO = 0;
    localparam int CTRL_KIND = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_OK = 2;
    localparam int STAT_NORSP = 3;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ==== rsd_link_if.sv ====
// Purpose: byte link between bus master and slave command interpreter
// Assumes: both ends on i_clk; one strobe per character time
// Notes: m_* flows master to slave, s_* slave to master
`timescale 1ns/1ps
interface rsd_link_if;
    logic [7:0] m_byte;
    logic m_vld;
    logic [7:0] s_byte;
    logic s_vld;
    modport master(output m_byte, output m_vld, input s_byte, input s_vld);
    modport slave(input m_byte, input m_vld, output s_byte, output s_vld);
endinterface

// ==== rsd_slave.sv ====
// Purpose: slave command interpreter, echo diagnosis and multi-word write
// Assumes: parameter store outside answers lock flags for o_par_addr
// Notes: frames end on an idle gap; replies reuse the frame buffer
// Behaviour
// R1 - idle gap of 3.5 chars delimits frames
// R2 - diagnosis sub-function zero echoes request exactly
// R3 - write carries up to sixteen words
// R4 - master sends write fields in fixed order
// R5 - words high byte first, successive addresses
// R6 - write reply echoes header, fresh check
// R7 - address high byte group, low index
// R8 - factory group never read nor written
// R9 - refuse running-locked and fixed parameter writes
// R10 - top address bit writes working copy only
// R11 - volatile-only address invalid for reads
// R12 - run mode 0..2, resets to 0
// R13 - power-down memory 0..1, resets to 0
// R14 - act on own station, reply with it
// R15 - check bytes low byte first
// R16 - byte count is twice word quantity
// R17 - reflected CRC-16 with polynomial A001
// R18 - bad check frames dropped silently
// R19 - bad count or quantity rejects write
`timescale 1ns/1ps
module rsd_slave import rsd_pkg::*; #(
    parameter int CHAR_CYC = CHAR_CYC_DEF,
    parameter int GAP_CYC = GAP_CYC_DEF
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    rsd_link_if.slave lnk,
    input wire logic [7:0] i_station,
    input wire logic i_running,
    input wire logic i_par_lock_run,
    input wire logic i_par_fixed,
    output logic [15:0] o_par_addr,
    output logic [15:0] o_par_data,
    output logic o_par_wr,
    output logic o_par_store,
    output logic [15:0] o_seq_run_mode,
    output logic [15:0] o_seq_pwr_mem
);
    typedef enum logic [2:0] {S_RX, S_CHK, S_WA, S_WD, S_TX} rsd_sst_t;

    rsd_sst_t st_q;
    logic [7:0] fr_q [BUF_LEN];
    logic [5:0] cnt_q;
    logic ovf_q;
    logic [15:0] crc_q;
    logic [31:0] idle_q;
    logic [31:0] tmr_q;
    logic [3:0] widx_q;
    logic [2:0] txi_q;
    logic [15:0] par_addr_q;
    logic [15:0] par_data_q;
    logic par_wr_q;
    logic par_store_q;
    logic [15:0] run_mode_q;
    logic [15:0] pwr_mem_q;
    logic [7:0] s_byte_q;
    logic s_vld_q;

    // =========================================================
    // frame decode
    wire rx_take = st_q == S_RX && lnk.m_vld && cnt_q < 6'(BUF_LEN);
    wire [15:0] qty = {fr_q[4], fr_q[5]};
    wire [7:0] bcnt = fr_q[6];
    // check residue over data plus check bytes is zero when intact
    wire frame_ok = crc_q == 16'h0000 && !ovf_q && cnt_q >= 6'h04 && fr_q[0] == i_station; // [R14] [R18] [R17]
    wire is_diag = fr_q[1] == CMD_DIAG && cnt_q == DIAG_LEN && {fr_q[2], fr_q[3]} == SUB_ECHO; // [R2]
    wire qty_ok = qty != 16'h0000 && qty <= MAX_WORDS; // [R3] [R19]
    wire bcnt_ok = {8'h00, bcnt} == (qty << 1) && {2'b00, cnt_q} == bcnt + WR_OVH; // [R16] [R19] [R4]
    wire is_wr = fr_q[1] == CMD_WRMULT && qty_ok && bcnt_ok;
    wire [5:0] dix = WR_HDR + {1'b0, widx_q, 1'b0};
    wire [15:0] wdata = {fr_q[dix], fr_q[dix + 6'h01]}; // [R5]
    wire [15:0] waddr = {fr_q[2], fr_q[3]} + {12'h000, widx_q}; // [R5]
    wire last_word = {12'h000, widx_q} == qty - 16'h0001;

    // =========================================================
    // write permission for the word on the parameter port
    // group in high byte, index in low byte; top bit is the volatile flag
    wire [15:0] pidx = {1'b0, par_addr_q[14:0]}; // [R7]
    wire factory = par_addr_q[14:8] == FACTORY_GRP; // [R8]
    wire is_run = pidx == ADDR_RUN_MODE;
    wire is_mem = pidx == ADDR_PWR_MEM;
    wire range_ok = is_run ? par_data_q <= RUN_MODE_MAX : (is_mem ? par_data_q <= PWR_MEM_MAX : 1'b1); // [R12] [R13]
    wire locked = i_par_fixed || (i_running && i_par_lock_run); // [R9]
    wire allow = !factory && !locked && range_ok;

    // =========================================================
    // reply byte: first six frame bytes, then check low, high
    wire [7:0] tx_byte = txi_q < 3'h6 ? fr_q[txi_q] : (txi_q == 3'h6 ? crc_q[7:0] : crc_q[15:8]); // [R15] [R6]

    always_ff @(posedge i_clk) begin
        if (rx_take) begin
            fr_q[cnt_q] <= lnk.m_byte;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= S_RX;
            cnt_q <= 6'h00;
            ovf_q <= 1'b0;
            crc_q <= CRC_INIT;
            idle_q <= 32'h0000_0000;
            tmr_q <= 32'h0000_0000;
            widx_q <= 4'h0;
            txi_q <= 3'h0;
            par_addr_q <= 16'h0000;
            par_data_q <= 16'h0000;
            par_wr_q <= 1'b0;
            par_store_q <= 1'b0;
            run_mode_q <= RUN_MODE_RST; // [R12]
            pwr_mem_q <= PWR_MEM_RST; // [R13]
            s_byte_q <= 8'h00;
            s_vld_q <= 1'b0;
        end else begin
            par_wr_q <= 1'b0;
            par_store_q <= 1'b0;
            s_vld_q <= 1'b0;
            case (st_q)
                S_RX: begin
                    if (lnk.m_vld) begin
                        idle_q <= 32'h0000_0000;
                        if (rx_take) begin
                            cnt_q <= cnt_q + 6'h01;
                            crc_q <= crc_byte(crc_q, lnk.m_byte);
                        end else begin
                            ovf_q <= 1'b1;
                        end
                    end else if (idle_q < 32'(GAP_CYC)) begin
                        idle_q <= idle_q + 32'h0000_0001;
                    end else if (cnt_q != 6'h00) begin
                        st_q <= S_CHK; // [R1]
                    end
                end
                S_CHK: begin
                    // reads and every other command fall through here unanswered
                    if (frame_ok && is_diag) begin
                        crc_q <= CRC_INIT;
                        txi_q <= 3'h0;
                        tmr_q <= 32'h0000_0000;
                        st_q <= S_TX; // [R2]
                    end else if (frame_ok && is_wr) begin
                        widx_q <= 4'h0;
                        st_q <= S_WA;
                    end else begin
                        cnt_q <= 6'h00; // [R18] [R19] [R11]
                        crc_q <= CRC_INIT;
                        ovf_q <= 1'b0;
                        st_q <= S_RX;
                    end
                end
                S_WA: begin
                    par_addr_q <= waddr;
                    par_data_q <= wdata;
                    st_q <= S_WD;
                end
                S_WD: begin
                    if (allow) begin
                        par_wr_q <= 1'b1; // [R8] [R9]
                        par_store_q <= !par_addr_q[VOL_BIT]; // [R10]
                        if (is_run) begin
                            run_mode_q <= par_data_q; // [R12]
                        end
                        if (is_mem) begin
                            pwr_mem_q <= par_data_q; // [R13]
                        end
                    end
                    if (last_word) begin
                        crc_q <= CRC_INIT;
                        txi_q <= 3'h0;
                        tmr_q <= 32'h0000_0000;
                        st_q <= S_TX; // [R6]
                    end else begin
                        widx_q <= widx_q + 4'h1;
                        st_q <= S_WA;
                    end
                end
                S_TX: begin
                    if (tmr_q != 32'h0000_0000) begin
                        tmr_q <= tmr_q - 32'h0000_0001;
                    end else begin
                        s_byte_q <= tx_byte; // [R14]
                        s_vld_q <= 1'b1;
                        tmr_q <= 32'(CHAR_CYC - 1);
                        if (txi_q < 3'h6) begin
                            crc_q <= crc_byte(crc_q, tx_byte); // [R17]
                        end
                        if (txi_q == 3'h7) begin
                            // rx restarts its gap count from the last reply byte
                            cnt_q <= 6'h00;
                            crc_q <= CRC_INIT;
                            ovf_q <= 1'b0;
                            idle_q <= 32'h0000_0000;
                            st_q <= S_RX;
                        end else begin
                            txi_q <= txi_q + 3'h1;
                        end
                    end
                end
                default: st_q <= S_RX;
            endcase
        end
    end

    assign lnk.s_byte = s_byte_q;
    assign lnk.s_vld = s_vld_q;
    assign o_par_addr = par_addr_q;
    assign o_par_data = par_data_q;
    assign o_par_wr = par_wr_q;
    assign o_par_store = par_store_q;
    assign o_seq_run_mode = run_mode_q;
    assign o_seq_pwr_mem = pwr_mem_q;
endmodule // rsd_slave

// ==== rsd_master.sv ====
// Purpose: bus master end, sends echo or multi-word write frames
// Assumes: software programs registers over APB, then sets go
// Notes: reply judged by check residue, length and header match
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module rsd_master import rsd_pkg::*; #(
    parameter int CHAR_CYC = CHAR_CYC_DEF,
    parameter int GAP_CYC = GAP_CYC_DEF,
    parameter int RSP_TMO_CYC = RSP_TMO_CYC_DEF
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    rsd_link_if.master lnk
);
    typedef enum logic [1:0] {M_IDLE, M_GAP, M_TX, M_RX} rsd_mst_t;

    rsd_mst_t st_q;
    logic [15:0] data_q [16];
    logic kind_q;
    logic [7:0] stn_q;
    logic [15:0] addr_q;
    logic [4:0] qty_q;
    logic done_q, ok_q, norsp_q, got_q, match_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [31:0] tmr_q;
    logic [5:0] idx_q;
    logic [15:0] crc_q;
    logic [7:0] m_byte_q;
    logic m_vld_q;
    logic [7:0] fb;

    // =========================================================
    // apb slave: no wait state, answer prepared in setup cycle
    wire setup = i_psel && !i_penable;
    wire apb_wr = i_psel && i_penable && pready_q && i_pwrite;
    wire is_data = i_paddr[11:6] == REG_DATA_PAGE;
    wire hit = is_data || i_paddr == REG_CTRL || i_paddr == REG_STN || i_paddr == REG_ADDR
        || i_paddr == REG_QTY || i_paddr == REG_STAT;
    wire [31:0] stat = {28'h0000000, norsp_q, ok_q, done_q, st_q != M_IDLE};
    wire [31:0] rd_val = is_data ? {16'h0000, data_q[i_paddr[5:2]]} :
        i_paddr == REG_CTRL ? {30'h00000000, kind_q, 1'b0} :
        i_paddr == REG_STN ? {24'h000000, stn_q} :
        i_paddr == REG_ADDR ? {16'h0000, addr_q} :
        i_paddr == REG_QTY ? {27'h0000000, qty_q} :
        i_paddr == REG_STAT ? stat : 32'h0000_0000;
    wire go = apb_wr && i_paddr == REG_CTRL && i_pwdata[CTRL_GO] && st_q == M_IDLE;

    // =========================================================
    // frame bytes by index
    // quantity kept within 1..16 so the master never oversends
    wire [7:0] qe = qty_q == 5'h00 ? 8'h01 : (qty_q > 5'h10 ? 8'h10 : {3'b000, qty_q}); // [R3]
    wire [5:0] nb = kind_q ? WR_HDR + {qe[4:0], 1'b0} : RSP_LEN;
    wire [5:0] di = idx_q - WR_HDR;
    wire [15:0] dw = data_q[di[4:1]];

    always_comb begin
        fb = 8'h00;
        case (idx_q)
            6'h00: fb = stn_q;
            6'h01: fb = kind_q ? CMD_WRMULT : CMD_DIAG;
            6'h02: fb = kind_q ? addr_q[15:8] : SUB_ECHO[15:8]; // [R4] [R7]
            6'h03: fb = kind_q ? addr_q[7:0] : SUB_ECHO[7:0];
            6'h04: fb = kind_q ? 8'h00 : addr_q[15:8];
            6'h05: fb = kind_q ? qe : addr_q[7:0];
            6'h06: fb = {qe[6:0], 1'b0}; // [R16]
            default: fb = di[0] ? dw[7:0] : dw[15:8]; // [R5]
        endcase
    end

    wire [7:0] tx_byte = idx_q == nb ? crc_q[7:0] : (idx_q == nb + 6'h01 ? crc_q[15:8] : fb); // [R15]

    always_ff @(posedge i_clk) begin
        if (apb_wr && is_data) begin
            data_q[i_paddr[5:2]] <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            kind_q <= 1'b0;
            stn_q <= 8'h01;
            addr_q <= 16'h0000;
            qty_q <= 5'h01;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q <= rd_val;
                pslverr_q <= !hit;
            end
            if (apb_wr && i_paddr == REG_CTRL && st_q == M_IDLE) begin
                kind_q <= i_pwdata[CTRL_KIND];
            end
            if (apb_wr && i_paddr == REG_STN) begin
                stn_q <= i_pwdata[7:0];
            end
            if (apb_wr && i_paddr == REG_ADDR) begin
                addr_q <= i_pwdata[15:0];
            end
            if (apb_wr && i_paddr == REG_QTY) begin
                qty_q <= i_pwdata[4:0];
            end
        end
    end

    // =========================================================
    // link sequencer
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= M_IDLE;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            norsp_q <= 1'b0;
            got_q <= 1'b0;
            match_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
            idx_q <= 6'h00;
            crc_q <= CRC_INIT;
            m_byte_q <= 8'h00;
            m_vld_q <= 1'b0;
        end else begin
            m_vld_q <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    if (go) begin
                        done_q <= 1'b0;
                        ok_q <= 1'b0;
                        norsp_q <= 1'b0;
                        tmr_q <= 32'h0000_0000;
                        st_q <= M_GAP;
                    end
                end
                M_GAP: begin
                    if (tmr_q < 32'(GAP_CYC)) begin
                        tmr_q <= tmr_q + 32'h0000_0001; // [R1]
                    end else begin
                        idx_q <= 6'h00;
                        crc_q <= CRC_INIT;
                        tmr_q <= 32'h0000_0000;
                        st_q <= M_TX;
                    end
                end
                M_TX: begin
                    if (tmr_q != 32'h0000_0000) begin
                        tmr_q <= tmr_q - 32'h0000_0001;
                    end else begin
                        m_byte_q <= tx_byte;
                        m_vld_q <= 1'b1;
                        tmr_q <= 32'(CHAR_CYC - 1);
                        if (idx_q < nb) begin
                            crc_q <= crc_byte(crc_q, tx_byte); // [R17]
                        end
                        if (idx_q == nb + 6'h01) begin
                            idx_q <= 6'h00;
                            crc_q <= CRC_INIT;
                            got_q <= 1'b0;
                            match_q <= 1'b1;
                            st_q <= M_RX;
                        end else begin
                            idx_q <= idx_q + 6'h01;
                        end
                    end
                end
                M_RX: begin
                    // reply header must repeat the first six request bytes
                    if (lnk.s_vld) begin
                        got_q <= 1'b1;
                        tmr_q <= 32'h0000_0000;
                        crc_q <= crc_byte(crc_q, lnk.s_byte);
                        if (idx_q < RSP_LEN && lnk.s_byte != fb) begin
                            match_q <= 1'b0; // [R2] [R6] [R14]
                        end
                        if (idx_q != 6'h3F) begin
                            idx_q <= idx_q + 6'h01;
                        end
                    end else if (!got_q && tmr_q >= 32'(RSP_TMO_CYC)) begin
                        norsp_q <= 1'b1;
                        done_q <= 1'b1;
                        st_q <= M_IDLE;
                    end else if (got_q && tmr_q >= 32'(GAP_CYC)) begin
                        ok_q <= match_q && crc_q == 16'h0000 && idx_q == DIAG_LEN; // [R1] [R15]
                        done_q <= 1'b1;
                        st_q <= M_IDLE;
                    end else begin
                        tmr_q <= tmr_q + 32'h0000_0001;
                    end
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign lnk.m_byte = m_byte_q;
    assign lnk.m_vld = m_vld_q;
endmodule // rsd_master

// ==== rsd_link_chk.sv ====
// Purpose: link checker beside the byte link of the two ends
// Assumes: one clock, character spacing of 4 cycles or more
// Notes: replies are judged against the last request seen
`timescale 1ns/1ps
module rsd_link_chk import rsd_pkg::*; #(
    parameter int GAP_CYC = 14 // short bench gap, keep equal to both ends
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] m_byte,
    input wire logic m_vld,
    input wire logic [7:0] s_byte,
    input wire logic s_vld
);
    // ==========
    // frame tracking
    logic [17:0] m_idle_q, s_idle_q;
    logic [5:0] m_idx_q, s_idx_q;
    logic [15:0] crc_q;
    logic [7:0] req_q [8];
    wire m_new = m_idle_q >= 18'(GAP_CYC);
    wire s_new = s_idle_q >= 18'(GAP_CYC);
    wire [5:0] m_pos = m_new ? 6'h00 : m_idx_q;
    wire [5:0] s_pos = s_new ? 6'h00 : s_idx_q;
    // idle counters saturate, so a closed reply stays closed
    wire s_end = s_new && s_idx_q != 6'h00;
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
        return r;
    endfunction
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            m_idle_q <= 18'(GAP_CYC);
            s_idle_q <= 18'(GAP_CYC);
            m_idx_q <= 6'h00;
            s_idx_q <= 6'h00;
            crc_q <= 16'hFFFF;
        end else begin
            m_idle_q <= m_vld ? 18'h0 : m_idle_q + {17'h0, !m_new};
            s_idle_q <= s_vld ? 18'h0 : s_idle_q + {17'h0, !s_new};
            if (m_vld) m_idx_q <= m_pos + 6'h01;
            if (s_vld) s_idx_q <= s_pos + 6'h01;
            if (s_vld) crc_q <= crc_step(s_new ? 16'hFFFF : crc_q, s_byte);
        end
    end
    always_ff @(posedge i_clk) begin
        if (m_vld && m_pos < 6'h08) req_q[m_pos[2:0]] <= m_byte;
    end
    // ==========
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence quiet3(sig);
        !sig [*3];
    endsequence
    m_spacing_a: assert property (m_vld |=> quiet3(m_vld))
        else $error("request bytes closer than a character");
    s_spacing_a: assert property (s_vld |=> quiet3(s_vld))
        else $error("reply bytes closer than a character");
    reply_gap_a: assert property (s_vld && s_pos == 6'h00 |-> m_idle_q >= 18'(GAP_CYC))
        else $error("reply began without an idle gap");
    reply_station_a: assert property (s_vld && s_pos == 6'h00 |-> s_byte == req_q[0])
        else $error("reply station differs from request");
    reply_header_a: assert property (s_vld && s_pos > 6'h00 && s_pos < 6'h06 |-> s_byte == req_q[s_pos[2:0]])
        else $error("reply header differs from request");
    echo_tail_a: assert property (s_vld && s_pos > 6'h05 && s_pos < 6'h08 && req_q[1] == CMD_DIAG
        |-> s_byte == req_q[s_pos[2:0]])
        else $error("echo check bytes differ from request");
    reply_len_a: assert property ($rose(s_end) |-> s_idx_q == 6'h08)
        else $error("reply length is not eight bytes");
    reply_crc_a: assert property (s_end |-> crc_q == 16'h0000)
        else $error("reply check bytes wrong");
endmodule // rsd_link_chk

// ==== testbench.sv ====
// Purpose: regression for master and slave ends joined by the link
// Assumes: short sim counts, slave station starts at 01
// Notes: master registers driven over APB
`timescale 1ns/1ps
module testbench import rsd_pkg::*;;
    // ==========
    // wiring
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic running = 1'b0, lock = 1'b0, fixed = 1'b0;
    logic [7:0] stn = 8'h01;
    localparam int T_CHAR = 4, T_GAP = 14, T_TMO = 200;
    wire [31:0] prdata;
    wire pready, pslverr, par_wr, par_store;
    wire [15:0] par_addr, par_data, run_mode, pwr_mem;
    int fail_count = 0, cmp_count = 0, wr_n = 0, st_n = 0, w0 = 0, s0 = 0;
    rsd_link_if lnk_if();
    rsd_master #(.CHAR_CYC(T_CHAR), .GAP_CYC(T_GAP), .RSP_TMO_CYC(T_TMO)) rsd_master_i (.i_clk(clk), .i_nrst(nrst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .lnk(lnk_if));
    rsd_slave #(.CHAR_CYC(T_CHAR), .GAP_CYC(T_GAP)) rsd_slave_i (.i_clk(clk), .i_nrst(nrst), .lnk(lnk_if),
        .i_station(stn), .i_running(running), .i_par_lock_run(lock), .i_par_fixed(fixed),
        .o_par_addr(par_addr), .o_par_data(par_data), .o_par_wr(par_wr), .o_par_store(par_store),
        .o_seq_run_mode(run_mode), .o_seq_pwr_mem(pwr_mem));
    rsd_link_chk rsd_link_chk_i (.i_clk(clk), .i_nrst(nrst), .m_byte(lnk_if.m_byte),
        .m_vld(lnk_if.m_vld), .s_byte(lnk_if.s_byte), .s_vld(lnk_if.s_vld));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (par_wr === 1'b1) wr_n++;
        if (par_store === 1'b1) st_n++;
    end
    // ==========
    // tasks
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // status polling bounded to 400 reads; a hang shows as a status mismatch, well before the watchdog
    task run(input logic [31:0] ctrl, input logic [15:0] ad, input logic [4:0] q, input logic [31:0] exp);
        int k;
        apb(1'b1, REG_ADDR, {16'h0, ad});
        apb(1'b1, REG_QTY, {27'h0, q});
        apb(1'b1, REG_CTRL, ctrl);
        rd = 32'h0;
        for (k = 0; k < 400 && rd[STAT_DONE] !== 1'b1; k++) apb(1'b0, REG_STAT, 32'h0);
        chk("status", rd, exp);
        $display("test kind %h at %h ends", ctrl, ad);
    endtask
    task wrs(input int ew, input int es);
        chk("writes", wr_n - w0, ew);
        chk("stores", st_n - s0, es);
        w0 = wr_n;
        s0 = st_n;
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("run_mode", {16'h0, run_mode}, 32'h0);
        chk("pwr_mem", {16'h0, pwr_mem}, 32'h0);
        run(32'h1, 16'h12AB, 5'h01, 32'h6);
        apb(1'b1, 12'h040, 32'h2);
        apb(1'b1, 12'h044, 32'h1);
        run(32'h3, ADDR_RUN_MODE, 5'h02, 32'h6);
        wrs(2, 2);
        chk("run_mode", {16'h0, run_mode}, 32'h2);
        chk("pwr_mem", {16'h0, pwr_mem}, 32'h1);
        apb(1'b1, 12'h040, 32'h3);
        apb(1'b1, 12'h044, 32'h2);
        run(32'h3, ADDR_RUN_MODE, 5'h02, 32'h6);
        wrs(0, 0);
        chk("run_mode", {16'h0, run_mode}, 32'h2);
        apb(1'b1, 12'h040, 32'h0);
        run(32'h3, 16'h8A00, 5'h01, 32'h6);
        wrs(1, 0);
        chk("run_mode", {16'h0, run_mode}, 32'h0);
        run(32'h3, 16'h6300, 5'h01, 32'h6);
        wrs(0, 0);
        running <= 1'b1;
        lock <= 1'b1;
        run(32'h3, 16'h0004, 5'h01, 32'h6);
        wrs(0, 0);
        running <= 1'b0;
        run(32'h3, 16'h0004, 5'h01, 32'h6);
        wrs(1, 1);
        fixed <= 1'b1;
        run(32'h3, 16'h0004, 5'h01, 32'h6);
        wrs(0, 0);
        fixed <= 1'b0;
        lock <= 1'b0;
        for (int i = 0; i < 16; i++) apb(1'b1, 12'h040 + 12'(4 * i), 32'(3 * i));
        run(32'h3, 16'h0105, 5'h10, 32'h6);
        wrs(16, 16);
        chk("last_addr", {16'h0, par_addr}, 32'h0114);
        chk("last_data", {16'h0, par_data}, 32'h002D);
        apb(1'b1, REG_STN, 32'h5);
        run(32'h1, 16'h0001, 5'h01, 32'hA);
        stn <= 8'h05;
        run(32'h1, 16'h0001, 5'h01, 32'h6);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        tally_and_finish;
    end
    initial begin
        #500_000;
        fail_count++;
        tally_and_finish;
    end
endmodule // testbench
